// ===== ltp_pkg.sv
// Summary of operation
// - compute each phase rms separately from 1 kHz samples of the three currents.
// - the largest of the three phase rms values is the heating current.
// - integrate the first-order thermal equation stepwise to get the rise above ambient.
// - thermal level tends to (i/in)^2, start level decays with same time constant.
// - object temperature is rise plus the ambient temperature in use.
// - compare temperature with thresholds, drive alarm, trip and restart-block outputs.
// - scaling uses rated current, rated temperature, base temperature, time constant.
// - at power-up preload the rise with startup fraction of the rated rise.
// - a boolean setting picks measured sensor or fixed ambient setting.
// - operation setting off disables the thermal protection.
// - pulsed mode gives a trip pulse when temperature rises above trip threshold.
// - locked mode holds trip from above trip threshold until below unlock threshold.
// - while the user block input is high the protection is blocked.
// - heat-reset input clears heat and loads the defined starting temperature.
// - when switched off no output status is produced at all; a restart-block fall at switch-off still sets the EV_BLK irq bit.
package ltp_pkg;
    localparam int          CUR_W        = 16;
    localparam int          TEMP_W       = 16;
    localparam int          FRAC_W       = 16;
    localparam int          CLK_HZ       = 10000000;
    localparam int          TICK_HZ      = 1000;
    localparam int          TICK_CYC     = CLK_HZ / TICK_HZ;
    localparam int          RMS_WIN      = 20;
    localparam logic [15:0] ALM_RST      = 16'h0050;
    localparam logic [15:0] TRIP_RST     = 16'h0064;
    localparam logic [15:0] RATED_RST    = 16'h0064;
    localparam logic [15:0] BASE_RST     = 16'h0019;
    localparam logic [15:0] UNL_RST      = 16'h003c;
    localparam logic [15:0] AMB_RST      = 16'h0019;
    localparam logic [15:0] STR_RST      = 16'h0000;
    localparam logic [15:0] INOM_RST     = 16'h0064;
    localparam logic [15:0] TAU_RST      = 16'h000a;
    localparam logic [1:0]  OPER_RST     = 2'h1;
    localparam logic [7:0]  A_CTRL       = 8'h00;
    localparam logic [7:0]  A_ALM        = 8'h04;
    localparam logic [7:0]  A_TRIP       = 8'h08;
    localparam logic [7:0]  A_RATED      = 8'h0c;
    localparam logic [7:0]  A_BASE       = 8'h10;
    localparam logic [7:0]  A_UNL        = 8'h14;
    localparam logic [7:0]  A_AMB        = 8'h18;
    localparam logic [7:0]  A_STR        = 8'h1c;
    localparam logic [7:0]  A_INOM       = 8'h20;
    localparam logic [7:0]  A_TAU        = 8'h24;
    localparam logic [7:0]  A_STAT       = 8'h28;
    localparam logic [7:0]  A_IRQ        = 8'h2c;
    localparam logic [7:0]  A_MASK       = 8'h30;
    localparam logic [7:0]  A_TEMP       = 8'h34;
    localparam logic [7:0]  A_HEAT       = 8'h38;
    localparam int          CTRL_OPER_LO = 0;
    localparam int          CTRL_SENS    = 2;
    localparam int          EV_ALM       = 0;
    localparam int          EV_TRIP      = 1;
    localparam int          EV_BLK       = 2;
    localparam int          EV_W         = 3;
    typedef enum logic [1:0] {LTP_OFF, LTP_PULSED, LTP_LOCKED} ltp_oper_e;
    typedef enum {LTP_IDLE, LTP_SQ, LTP_STEP} ltp_state_e;
endpackage

// ===== ltp_rms.sv
`timescale 1ns/100ps
module ltp_rms
    import ltp_pkg::*;
#(
    parameter int WIN = RMS_WIN
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             tick,
    input  wire logic [CUR_W-1:0] sample,
    output logic      [CUR_W-1:0] rms
);
    // mean square over consecutive fixed blocks of WIN samples (the first block after reset holds WIN-1), then integer root
    logic [47:0]      acc_q, acc_d;
    logic [7:0]       cnt_q, cnt_d;
    logic [CUR_W-1:0] rms_q, rms_d;
    logic [31:0]      ms;
    logic [15:0]      sq;

    function automatic logic [15:0] isqrt(input logic [31:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int b = 15; b >= 0; b--) begin
            if ({16'h0000, r | (16'h0001 << b)} * {16'h0000, r | (16'h0001 << b)} <= {32'h0, v})
                r = r | (16'h0001 << b);
        end
        return r;
    endfunction

    always_comb begin
        acc_d = acc_q;
        cnt_d = cnt_q;
        rms_d = rms_q;
        ms    = 32'(acc_q / 48'(WIN));
        sq    = isqrt(ms);
        if (tick) begin
            if (cnt_q == 8'(WIN - 1)) begin
                rms_d = sq;
                acc_d = 48'({16'h0000, sample} * {16'h0000, sample});
                cnt_d = 8'h00;
            end else begin
                acc_d = acc_q + 48'({16'h0000, sample} * {16'h0000, sample});
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            acc_q <= 48'h0000_0000_0000;
            cnt_q <= 8'h00;
            rms_q <= 16'h0000;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            rms_q <= rms_d;
        end
    end

    assign rms = rms_q;
endmodule

// ===== ltp_tick.sv
`timescale 1ns/100ps
module ltp_tick
    import ltp_pkg::*;
#(
    parameter int DIV = TICK_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    output logic      tick
);
    logic [15:0] cnt_q, cnt_d;
    logic        tick_q, tick_d;

    always_comb begin
        tick_d = 1'b0;
        cnt_d  = cnt_q + 16'h0001;
        if (cnt_q == 16'(DIV - 1)) begin
            cnt_d  = 16'h0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// ===== line_thermal_protection.sv
`timescale 1ns/100ps
module line_thermal_protection
    import ltp_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic [CUR_W-1:0]  i_ph_a,
    input  wire logic [CUR_W-1:0]  i_ph_b,
    input  wire logic [CUR_W-1:0]  i_ph_c,
    input  wire logic [TEMP_W-1:0] sensor_temp,
    input  wire logic              block_in,
    input  wire logic              heat_reset,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    output logic                   alarm,
    output logic                   trip,
    output logic                   restart_block,
    output logic                   irq
);
    logic              tick;
    logic [CUR_W-1:0]  rms [3];
    logic [CUR_W-1:0]  ph [3];

    assign ph[0] = i_ph_a;
    assign ph[1] = i_ph_b;
    assign ph[2] = i_ph_c;

    ltp_tick #(.DIV(TICK_DIV)) u_tick (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .tick    (tick)
    );

    for (genvar g = 0; g < 3; g++) begin : g_rms
        ltp_rms u_rms (
            .ref_clk (ref_clk),
            .rstn    (rstn),
            .tick    (tick),
            .sample  (ph[g]),
            .rms     (rms[g])
        );
    end

    // settings, irq status and read data
    logic [1:0]      oper_q;
    logic [1:0]      oper_d;
    logic            sens_q;
    logic            sens_d;
    logic [15:0]     alm_q;
    logic [15:0]     alm_d;
    logic [15:0]     trp_q;
    logic [15:0]     trp_d;
    logic [15:0]     rated_q;
    logic [15:0]     rated_d;
    logic [15:0]     base_q;
    logic [15:0]     base_d;
    logic [15:0]     unl_q;
    logic [15:0]     unl_d;
    logic [15:0]     amb_q;
    logic [15:0]     amb_d;
    logic [15:0]     str_q;
    logic [15:0]     str_d;
    logic [15:0]     inom_q;
    logic [15:0]     inom_d;
    logic [15:0]     tau_q;
    logic [15:0]     tau_d;
    logic [EV_W-1:0] st_q;
    logic [EV_W-1:0] st_d;
    logic [EV_W-1:0] mask_q;
    logic [EV_W-1:0] mask_d;
    logic [31:0]     rdata_q;
    logic [31:0]     rdata_d;

    // thermal state: upper word of heat is the level h in units of rated rise with
    // FRAC_W fraction bits; the low word keeps tiny steps of long time constants
    ltp_state_e      state_q;
    ltp_state_e      state_d;
    logic [63:0]     heat_q;
    logic [63:0]     heat_d;
    logic [31:0]     tgt_q;
    logic [31:0]     tgt_d;
    logic [31:0]     decay_q;
    logic [31:0]     decay_d;
    logic [15:0]     temp_q;
    logic [15:0]     temp_d;
    logic            alm_o_q;
    logic            alm_o_d;
    logic            trip_o_q;
    logic            trip_o_d;
    logic            rb_o_q;
    logic            rb_o_d;
    logic            lock_q;
    logic            lock_d;
    logic            above_q;
    logic            above_d;

    logic [CUR_W-1:0] imax;
    logic [15:0]      amb_use;
    logic [15:0]      rise_n;
    logic [31:0]      ratio;
    logic [31:0]      rise;
    logic [63:0]      tgt_w;
    logic [63:0]      blend;
    logic             active;
    logic [EV_W-1:0]  ev;

    function automatic logic [CUR_W-1:0] max2(input logic [CUR_W-1:0] a,
                                               input logic [CUR_W-1:0] b);
        return (a > b) ? a : b;
    endfunction

    always_comb begin
        imax    = max2(max2(rms[0], rms[1]), rms[2]);
        amb_use = sens_q ? sensor_temp : amb_q;
        rise_n  = (rated_q > base_q) ? (rated_q - base_q) : 16'h0000;
        active  = (oper_q != 2'(LTP_OFF)) && !block_in;
        // ratio = imax / (inom% of nominal) with fraction bits; inputs in % of nominal
        ratio   = (inom_q == 16'h0000) ? 32'h0000_0000
                : 32'(({32'h0, imax} << FRAC_W) / {48'h0, inom_q});
        blend   = 64'h0;
        tgt_w   = {tgt_q, 32'h0000_0000};
        rise    = 32'((64'(heat_q[63:32]) * 64'(rise_n)) >> FRAC_W);
        state_d = state_q;
        heat_d  = heat_q;
        tgt_d   = tgt_q;
        decay_d = decay_q;
        temp_d  = 16'(rise) + amb_use;
        case (state_q)
            LTP_IDLE: begin
                if (tick)
                    state_d = LTP_SQ;
            end
            LTP_SQ: begin
                // target (i/in)^2; per-step factor 1/(60000*tau) with 2*FRAC_W fraction bits
                tgt_d   = 32'((64'(ratio) * 64'(ratio)) >> FRAC_W);
                decay_d = (tau_q == 16'h0000) ? 32'hffff_ffff
                        : 32'((64'h1 << (2 * FRAC_W)) / (64'd60000 * 64'(tau_q)));
                state_d = LTP_STEP;
            end
            LTP_STEP: begin
                // h += (target - h) / (T/dt); euler step, decay is tiny so it stays stable
                if (tgt_w >= heat_q)
                    blend = heat_q + 64'((96'(tgt_w - heat_q) * 96'(decay_q)) >> (2 * FRAC_W));
                else
                    blend = heat_q - 64'((96'(heat_q - tgt_w) * 96'(decay_q)) >> (2 * FRAC_W));
                heat_d  = blend;
                state_d = LTP_IDLE;
            end
            default: state_d = LTP_IDLE;
        endcase
        if (heat_reset)
            heat_d = {32'((64'(str_q) << FRAC_W) / 64'd100), 32'h0000_0000};
    end

    always_comb begin
        alm_o_d = 1'b0;
        trip_o_d = 1'b0;
        rb_o_d  = 1'b0;
        lock_d  = lock_q;
        above_d = temp_q > trp_q;
        if (active) begin
            alm_o_d = temp_q > alm_q;
            rb_o_d  = temp_q >= unl_q;
            if (oper_q == 2'(LTP_PULSED))
                trip_o_d = above_d && !above_q;
            else begin
                if (temp_q > trp_q)
                    lock_d = 1'b1;
                else if (temp_q < unl_q)
                    lock_d = 1'b0;
                trip_o_d = lock_d;
            end
        end else
            lock_d = 1'b0;
    end

    assign ev = {rb_o_q & ~rb_o_d, trip_o_d & ~trip_o_q, alm_o_d & ~alm_o_q};

    always_comb begin
        oper_d = oper_q;
        sens_d = sens_q;
        alm_d  = alm_q;
        trp_d  = trp_q;
        rated_d = rated_q;
        base_d = base_q;
        unl_d  = unl_q;
        amb_d  = amb_q;
        str_d  = str_q;
        inom_d = inom_q;
        tau_d  = tau_q;
        mask_d = mask_q;
        st_d   = st_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                A_CTRL: begin
                    oper_d = reg_wdata[CTRL_OPER_LO +: 2];
                    sens_d = reg_wdata[CTRL_SENS];
                end
                A_ALM:   alm_d   = reg_wdata[15:0];
                A_TRIP:  trp_d   = reg_wdata[15:0];
                A_RATED: rated_d = reg_wdata[15:0];
                A_BASE:  base_d  = reg_wdata[15:0];
                A_UNL:   unl_d   = reg_wdata[15:0];
                A_AMB:   amb_d   = reg_wdata[15:0];
                A_STR:   str_d   = reg_wdata[15:0];
                A_INOM:  inom_d  = reg_wdata[15:0];
                A_TAU:   tau_d   = reg_wdata[15:0];
                A_IRQ:   st_d    = st_q & ~reg_wdata[EV_W-1:0];
                A_MASK:  mask_d  = reg_wdata[EV_W-1:0];
                default: ;
            endcase
        end
        // set wins over write-one-to-clear
        st_d = st_d | ev;
        if (reg_rd) begin
            case (reg_addr)
                A_CTRL:  rdata_d = {29'h0, sens_q, oper_q};
                A_ALM:   rdata_d = {16'h0000, alm_q};
                A_TRIP:  rdata_d = {16'h0000, trp_q};
                A_RATED: rdata_d = {16'h0000, rated_q};
                A_BASE:  rdata_d = {16'h0000, base_q};
                A_UNL:   rdata_d = {16'h0000, unl_q};
                A_AMB:   rdata_d = {16'h0000, amb_q};
                A_STR:   rdata_d = {16'h0000, str_q};
                A_INOM:  rdata_d = {16'h0000, inom_q};
                A_TAU:   rdata_d = {16'h0000, tau_q};
                A_STAT:  rdata_d = {29'h0, rb_o_q, trip_o_q, alm_o_q};
                A_IRQ:   rdata_d = {29'h0, st_q};
                A_MASK:  rdata_d = {29'h0, mask_q};
                A_TEMP:  rdata_d = {16'h0000, temp_q};
                A_HEAT:  rdata_d = heat_q[63:32];
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            oper_q  <= OPER_RST;
            sens_q  <= 1'b0;
            alm_q   <= ALM_RST;
            trp_q   <= TRIP_RST;
            rated_q <= RATED_RST;
            base_q  <= BASE_RST;
            unl_q   <= UNL_RST;
            amb_q   <= AMB_RST;
            str_q   <= STR_RST;
            inom_q  <= INOM_RST;
            tau_q   <= TAU_RST;
            mask_q  <= 3'h0;
            st_q    <= 3'h0;
            rdata_q <= 32'h0000_0000;
            state_q <= LTP_IDLE;
            // power-up preload from the reset value of the startup setting
            heat_q  <= {32'((64'(STR_RST) << FRAC_W) / 64'd100), 32'h0000_0000};
            tgt_q   <= 32'h0000_0000;
            decay_q <= 32'h0000_0000;
            temp_q  <= 16'h0000;
            alm_o_q <= 1'b0;
            trip_o_q <= 1'b0;
            rb_o_q  <= 1'b0;
            lock_q  <= 1'b0;
            above_q <= 1'b0;
        end else begin
            oper_q  <= oper_d;
            sens_q  <= sens_d;
            alm_q   <= alm_d;
            trp_q   <= trp_d;
            rated_q <= rated_d;
            base_q  <= base_d;
            unl_q   <= unl_d;
            amb_q   <= amb_d;
            str_q   <= str_d;
            inom_q  <= inom_d;
            tau_q   <= tau_d;
            mask_q  <= mask_d;
            st_q    <= st_d;
            rdata_q <= rdata_d;
            state_q <= state_d;
            heat_q  <= heat_d;
            tgt_q   <= tgt_d;
            decay_q <= decay_d;
            temp_q  <= temp_d;
            alm_o_q <= alm_o_d;
            trip_o_q <= trip_o_d;
            rb_o_q  <= rb_o_d;
            lock_q  <= lock_d;
            above_q <= above_d;
        end
    end

    assign reg_rdata     = rdata_q;
    assign alarm         = alm_o_q;
    assign trip          = trip_o_q;
    assign restart_block = rb_o_q;
    assign irq           = |(st_q & mask_q);
endmodule

// ===== ltp_properties.sv
`timescale 1ns/100ps
module ltp_properties
    import ltp_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYC
) (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        block_in,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        alarm,
    input wire logic        trip,
    input wire logic        restart_block,
    input wire logic        irq
);
    // shadow mode and mask, rebuilt from bus writes since the mode and mask registers are not visible here
    logic [1:0] mode_q, mode_d;
    logic [2:0] mask_q, mask_d;
    always_comb begin
        mode_d = mode_q;
        mask_d = mask_q;
        if (!rstn) begin
            mode_d = OPER_RST;
            mask_d = 3'h0;
        end else if (reg_wr && reg_addr == A_CTRL) begin
            mode_d = reg_wdata[1:0];
        end else if (reg_wr && reg_addr == A_MASK) begin
            mask_d = reg_wdata[2:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        mode_q <= mode_d;
        mask_q <= mask_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    reset_quiet_a: assert property (
        $rose(rstn) |-> !alarm && !trip && !restart_block)
        else $error("status high after reset");
    block_quiet_a: assert property (
        block_in [*4] |-> !alarm && !trip && !restart_block)
        else $error("status high while blocked");
    off_quiet_a: assert property (
        (mode_q == 2'h0) [*4] |-> !alarm && !trip && !restart_block)
        else $error("status high while off");
    trip_pulse_a: assert property (
        trip && mode_q == 2'h1 && !(reg_wr && reg_addr == A_CTRL) |=> !trip)
        else $error("pulsed trip longer than one cycle");
    lock_release_a: assert property (
        $fell(trip) && mode_q == 2'h2 && $past(mode_q) == 2'h2 |-> !restart_block)
        else $error("locked trip dropped above unlock level");
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data without read");
    ctrl_readback_a: assert property (
        reg_rd && reg_addr == A_CTRL |=> reg_rdata[1:0] == $past(mode_q))
        else $error("mode readback differs");
    mask_off_a: assert property (
        reg_wr && reg_addr == A_MASK && reg_wdata[2:0] == 3'h0 |=> !irq)
        else $error("irq with all events masked");
    alarm_irq_a: assert property (
        $rose(alarm) && mask_q[EV_ALM] |-> ##[0:2] irq)
        else $error("alarm rise gave no irq");
    trip_irq_a: assert property (
        $rose(trip) && mask_q[EV_TRIP] |-> ##[0:2] irq)
        else $error("trip rise gave no irq");
endmodule
bind line_thermal_protection ltp_properties #(.TICK_DIV(TICK_DIV)) u_props (
    .ref_clk(ref_clk), .rstn(rstn), .block_in(block_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .alarm(alarm), .trip(trip), .restart_block(restart_block), .irq(irq));

// ===== ltp_front.sv
`timescale 1ns/100ps
module ltp_front
    import ltp_pkg::*;
(
    input  wire logic [3*CUR_W-1:0] amp_set,
    input  wire logic               ref_clk,
    input  wire logic [TEMP_W-1:0]  temp_set,
    input  wire logic               blk_set,
    input  wire logic               hrst_set,
    output logic      [CUR_W-1:0]   i_ph_a,
    output logic      [CUR_W-1:0]   i_ph_b,
    output logic      [CUR_W-1:0]   i_ph_c,
    output logic      [TEMP_W-1:0]  sensor_temp,
    output logic                    block_in,
    output logic                    heat_reset
);
    // every line is launched off a clock edge, so the block never sees a mid-cycle step
    always_ff @(posedge ref_clk) begin
        i_ph_a      <= amp_set[47:32];
        i_ph_b      <= amp_set[31:16];
        i_ph_c      <= amp_set[15:0];
        sensor_temp <= temp_set;
        block_in    <= blk_set;
        heat_reset  <= hrst_set;
    end
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top
    import ltp_pkg::*;
();
    localparam int TDIV = 10;
    logic        ref_clk = 1'b0;
    logic        rstn, reg_wr, reg_rd, alarm, trip, restart_block, irq;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdv;
    logic [47:0] amp_set;
    logic [15:0] temp_set, i_ph_a, i_ph_b, i_ph_c, sensor_temp;
    logic        blk_set, hrst_set, block_in, heat_reset;
    int          fails = 0;
    int          checked = 0;
    int          n;
    // sensor level, then expected {alarm, trip, restart_block} in locked mode
    logic [18:0] rows [9] = '{{16'h0032, 3'h0}, {16'h0046, 3'h1}, {16'h0050, 3'h1},
        {16'h0051, 3'h5}, {16'h0064, 3'h5}, {16'h0065, 3'h7}, {16'h0046, 3'h3},
        {16'h003c, 3'h3}, {16'h003b, 3'h0}};
    always #50 ref_clk = ~ref_clk;
    ltp_front u_front (.amp_set(amp_set), .ref_clk(ref_clk), .temp_set(temp_set),
        .blk_set(blk_set), .hrst_set(hrst_set), .i_ph_a(i_ph_a), .i_ph_b(i_ph_b),
        .i_ph_c(i_ph_c), .sensor_temp(sensor_temp), .block_in(block_in),
        .heat_reset(heat_reset));
    line_thermal_protection #(.TICK_DIV(TDIV)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
        .i_ph_a(i_ph_a), .i_ph_b(i_ph_b), .i_ph_c(i_ph_c), .sensor_temp(sensor_temp),
        .block_in(block_in), .heat_reset(heat_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .alarm(alarm), .trip(trip), .restart_block(restart_block), .irq(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // every bus task returns 1 ns after the edge that took the request
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check(rdv, e);
    endtask
    // fixed wait: temperature and outputs settle within a few cycles of a tick
    task automatic ticks(input int k);
        repeat (k * TDIV) @(posedge ref_clk);
        #1;
    endtask
    task automatic outs(input logic [2:0] e);
        check({29'h0, alarm, trip, restart_block}, {29'h0, e});
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
    initial begin
        rstn = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {amp_set, temp_set, blk_set, hrst_set} = '0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        outs(3'h0);
        rd_chk(A_ALM, 32'h0000_0050);
        rd_chk(A_UNL, 32'h0000_003c);
        rd_chk(8'h3c, 32'h0000_0000);
        ticks(3);
        rd_chk(A_TEMP, 32'h0000_0019);
        // heat held at a zero start, so the temperature follows the sensor alone
        hrst_set <= 1'b1;
        wr(A_CTRL, 32'h0000_0006);
        foreach (rows[i]) begin
            temp_set <= rows[i][18:3];
            ticks(3);
            outs(rows[i][2:0]);
            rd_chk(A_TEMP, {16'h0000, rows[i][18:3]});
        end
        wr(A_CTRL, 32'h0000_0005);
        wr(A_IRQ, 32'h0000_0007);
        wr(A_MASK, 32'h0000_0007);
        check({31'h0, irq}, 32'h0000_0000);
        temp_set <= 16'h0065;
        n = 0;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            n += trip;
        end
        check(n, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
        rd_chk(A_IRQ, 32'h0000_0003);
        wr(A_IRQ, 32'h0000_0003);
        check({31'h0, irq}, 32'h0000_0000);
        temp_set <= 16'h0032;
        ticks(3);
        check({31'h0, irq}, 32'h0000_0001);
        wr(A_MASK, 32'h0000_0003);
        check({31'h0, irq}, 32'h0000_0000);
        wr(A_IRQ, 32'h0000_0004);
        wr(A_MASK, 32'h0000_0007);
        check({31'h0, irq}, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0004);
        temp_set <= 16'h0065;
        ticks(3);
        outs(3'h0);
        wr(A_CTRL, 32'h0000_0006);
        blk_set <= 1'b1;
        ticks(3);
        outs(3'h0);
        blk_set <= 1'b0;
        ticks(3);
        outs(3'h7);
        // fixed ambient, half start fraction of a 100 degree rated rise
        wr(A_CTRL, 32'h0000_0002);
        wr(A_RATED, 32'h0000_007d);
        wr(A_STR, 32'h0000_0032);
        ticks(3);
        rd_chk(A_HEAT, 32'h0000_8000);
        rd_chk(A_TEMP, 32'h0000_004b);
        wr(A_AMB, 32'h0000_001e);
        ticks(3);
        rd_chk(A_TEMP, 32'h0000_0050);
        outs(3'h1);
        wr(A_STR, 32'h0000_0000);
        wr(A_TAU, 32'h0000_0001);
        amp_set <= {16'h0000, 16'h0064, 16'h0000};
        ticks(3);
        hrst_set <= 1'b0;
        ticks(60);
        rd(A_HEAT);
        // one minute constant: the level climbs about one 16-bit fraction step per tick
        check({31'h0, rdv != 32'h0000_0000}, 32'h0000_0001);
        check({31'h0, rdv < 32'h0000_0050}, 32'h0000_0001);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        outs(3'h0);
        rd_chk(A_CTRL, 32'h0000_0001);
        tally_and_finish();
    end
endmodule
